//--- inc/pld_pkg.sv
/*
 * package for the lock detect and loop control block: register map, field
 * positions, reset values, state enum and structs.
 * assumes an AXI4-Lite master on a 10 MHz aclk, synchronous low reset.
 */
`default_nettype none
package pld_pkg;
    // byte addresses: printed register numbers times four
    localparam logic [7:0]  ADDR_ENABLE    = 8'h04;  // enable and reset register
    localparam logic [7:0]  ADDR_PUMP_GAIN = 8'h1C;
    localparam logic [7:0]  ADDR_PUMP_TRIM = 8'h20;
    localparam logic [7:0]  ADDR_INTG      = 8'h3C;
    localparam logic [7:0]  ADDR_DSM_CFG   = 8'h48;
    localparam logic [7:0]  ADDR_LOCK_CFG  = 8'h68;
    localparam logic [7:0]  ADDR_SLIP_CFG  = 8'h70;
    localparam logic [7:0]  ADDR_STATUS    = 8'h7C;
    // field positions
    localparam int EN_LOCK_BIT   = 11;
    localparam int EN_DSM_BIT    = 13;
    localparam int EN_SLIP_BIT   = 15;
    localparam int LK_FORCE_BIT  = 13;
    localparam int LK_SHARE_BIT  = 12;
    localparam int LK_LATE_BIT   = 11;
    localparam int LK_SKEW_BIT   = 10;
    localparam int DSM_INT_BIT   = 3;
    localparam int GAIN_FALL_LSB = 5;
    localparam int TRIM_FALL_LSB = 3;
    localparam int LEAK_RISE_LSB = 6;
    localparam int LEAK_FALL_LSB = 10;
    // reset values: modulator running, fractional mode
    localparam logic [15:0] ENABLE_RST   = 16'h2000;
    localparam logic [15:0] INTG_RST     = 16'h0024;
    localparam logic [15:0] MIN_DIVIDE   = 16'h0020;  // divider floor
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {PLD_IDLE, PLD_WRESP, PLD_RRESP} pld_bus_t;

    // one arrival at the phase detector, one cycle pulse
    typedef struct packed {
        logic       valid;
        logic       in_early;   // arrived inside the early-skewed window
        logic       in_center;  // inside the centered window
        logic       in_late;    // inside the late-skewed window
        logic       freq_near;  // frequency difference near zero
        logic       vco_lead;   // divided vco ahead of reference
    } pld_arrival_t;

    // analog-facing setting codes
    typedef struct packed {
        logic [4:0] pump_rise_gain;
        logic [4:0] pump_fall_gain;
        logic [2:0] pump_rise_fine;
        logic [2:0] pump_fall_fine;
        logic [3:0] pump_rise_leak;
        logic [3:0] pump_fall_leak;
        logic       detector_gain_max;
        logic       modulator_run;
        logic [15:0] divide_value;
    } pld_loop_t;

    typedef struct packed {
        pld_bus_t    bus;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic        aw_seen;
        logic        w_seen;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [15:0] enable;
        logic [9:0]  win_target;
        logic [3:0]  lock_mode;
        logic [9:0]  gain_codes;
        logic [13:0] trim_codes;
        logic [15:0] intg;
        logic        dsm_int;
        logic [3:0]  slip_depth;
        logic [9:0]  hit_count;
        logic        lock_flag;
        logic        reading;
        logic        guard_on;
    } pld_state_t;
endpackage : pld_pkg
`default_nettype wire

//--- core/pld_core.sv
/*
 * lock detector, slip guard control, pump codes and mode selection.
 * assumes a phase detector front end that reports each arrival as a pulse
 * of pld_arrival_t, and an AXI4-Lite master standing in for the serial host.
 */
`timescale 1ns/1ps
`default_nettype none
module pld_core
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire pld_pkg::pld_arrival_t arrival,
    input  wire logic                  serial_data_out,
    output logic                       lock_or_serial_out_pin,
    output logic                       lock_flag,
    output pld_pkg::pld_loop_t         loop_ctrl
);
    import pld_pkg::*;

    pld_state_t st_reg;
    pld_state_t st_next;
    logic       in_window;
    logic       hit;
    logic       miss;
    logic [15:0] nudged;
    logic [31:0] wmask;

    // window choice by skew bits
    always_comb
    begin
        if (!st_reg.lock_mode[LK_SKEW_BIT - LK_SKEW_BIT])
            in_window = arrival.in_center;
        else if (st_reg.lock_mode[LK_LATE_BIT - LK_SKEW_BIT])
            in_window = arrival.in_late;
        else
            in_window = arrival.in_early;
    end

    assign hit  = arrival.valid && in_window;
    assign miss = arrival.valid && !in_window;
    assign wmask = {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}}, {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};

    // slip guard divide: step by depth, clamp at floor
    always_comb
    begin
        nudged = st_reg.intg;
        if (st_reg.guard_on)
        begin
            if (arrival.vco_lead)
                nudged = st_reg.intg + {12'h000, st_reg.slip_depth};
            else if (st_reg.intg > MIN_DIVIDE + {12'h000, st_reg.slip_depth})
                nudged = st_reg.intg - {12'h000, st_reg.slip_depth};
            else
                nudged = MIN_DIVIDE;
        end
    end

    // next-state logic: bus slave and lock detector
    always_comb
    begin
        st_next = st_reg;
        // bus
        case (st_reg.bus)
            PLD_IDLE:
            begin
                if (s_axi_awvalid && !st_reg.aw_seen)
                begin
                    st_next.aw_seen = 1'b1;
                    st_next.awaddr  = s_axi_awaddr;
                end
                if (s_axi_wvalid && !st_reg.w_seen)
                begin
                    st_next.w_seen = 1'b1;
                    st_next.wdata  = s_axi_wdata;
                    st_next.wstrb  = s_axi_wstrb;
                end
                if (st_reg.aw_seen && st_reg.w_seen)
                begin
                    st_next.aw_seen = 1'b0;
                    st_next.w_seen  = 1'b0;
                    st_next.bus     = PLD_WRESP;
                    st_next.resp    = RESP_OKAY;
                    case (st_reg.awaddr)
                        ADDR_ENABLE:    st_next.enable = (st_reg.enable & ~wmask[15:0]) | (st_reg.wdata[15:0] & wmask[15:0]);
                        ADDR_PUMP_GAIN: st_next.gain_codes = st_reg.wdata[9:0];
                        ADDR_PUMP_TRIM: st_next.trim_codes = st_reg.wdata[13:0];
                        ADDR_INTG:      st_next.intg = st_reg.wdata[15:0];
                        ADDR_DSM_CFG:   st_next.dsm_int = st_reg.wdata[DSM_INT_BIT];
                        ADDR_LOCK_CFG:
                        begin
                            st_next.win_target = st_reg.wdata[9:0];
                            st_next.lock_mode  = st_reg.wdata[LK_FORCE_BIT:LK_SKEW_BIT];
                        end
                        ADDR_SLIP_CFG:  st_next.slip_depth = st_reg.wdata[3:0];
                        ADDR_STATUS:    st_next.resp = RESP_OKAY;                  // read only
                        default:        st_next.resp = RESP_SLVERR;
                    endcase
                end
                else if (s_axi_arvalid && !st_reg.aw_seen && !st_reg.w_seen)
                begin
                    st_next.bus     = PLD_RRESP;
                    st_next.reading = 1'b1;
                    st_next.resp    = RESP_OKAY;
                    st_next.rdata   = 32'h0000_0000;
                    case (s_axi_araddr)
                        ADDR_ENABLE:    st_next.rdata[15:0] = st_reg.enable;
                        ADDR_PUMP_GAIN: st_next.rdata[9:0]  = st_reg.gain_codes;
                        ADDR_PUMP_TRIM: st_next.rdata[13:0] = st_reg.trim_codes;
                        ADDR_INTG:      st_next.rdata[15:0] = st_reg.intg;
                        ADDR_DSM_CFG:   st_next.rdata[DSM_INT_BIT] = st_reg.dsm_int;
                        ADDR_LOCK_CFG:
                        begin
                            st_next.rdata[9:0] = st_reg.win_target;
                            st_next.rdata[LK_FORCE_BIT:LK_SKEW_BIT] = st_reg.lock_mode;
                        end
                        ADDR_SLIP_CFG:  st_next.rdata[3:0] = st_reg.slip_depth;
                        ADDR_STATUS:    st_next.rdata[0] = st_reg.lock_flag;
                        default:        st_next.resp = RESP_SLVERR;
                    endcase
                end
            end
            PLD_WRESP:
                if (s_axi_bready)
                    st_next.bus = PLD_IDLE;
            PLD_RRESP:
                if (s_axi_rready)
                begin
                    st_next.bus     = PLD_IDLE;
                    st_next.reading = 1'b0;  // in share mode the pin returns to lock flag
                end
            default:
                st_next.bus = PLD_IDLE;
        endcase

        // lock detector
        if (!st_reg.enable[EN_LOCK_BIT])
        begin
            st_next.hit_count = 10'h000;
            st_next.lock_flag = 1'b0;
        end
        else if (miss)
        begin
            st_next.hit_count = 10'h000;
            st_next.lock_flag = 1'b0;
        end
        else if (hit)
        begin
            if (st_reg.hit_count + 10'h001 >= st_reg.win_target)
                st_next.lock_flag = 1'b1;
            if (st_reg.hit_count != 10'h3FF)
                st_next.hit_count = st_reg.hit_count + 10'h001;
        end

        // slip guard active while enabled and frequency far
        st_next.guard_on = st_reg.enable[EN_SLIP_BIT] && !arrival.freq_near;
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg        <= '0;
            st_reg.bus    <= PLD_IDLE;
            st_reg.enable <= ENABLE_RST;
            st_reg.intg   <= INTG_RST;
        end
        else
            st_reg <= st_next;
    end

    // bus outputs
    assign s_axi_awready = (st_reg.bus == PLD_IDLE) && !st_reg.aw_seen;
    assign s_axi_wready  = (st_reg.bus == PLD_IDLE) && !st_reg.w_seen;
    assign s_axi_arready = (st_reg.bus == PLD_IDLE) && !st_reg.aw_seen && !st_reg.w_seen
                           && !(st_reg.aw_seen && st_reg.w_seen);
    assign s_axi_bvalid  = (st_reg.bus == PLD_WRESP);
    assign s_axi_bresp   = st_reg.resp;
    assign s_axi_rvalid  = (st_reg.bus == PLD_RRESP);
    assign s_axi_rresp   = st_reg.resp;
    assign s_axi_rdata   = st_reg.rdata;
    assign lock_flag     = st_reg.lock_flag;

    // shared pin: force, share with reads, else serial out
    always_comb
    begin
        if (st_reg.lock_mode[LK_FORCE_BIT - LK_SKEW_BIT])
            lock_or_serial_out_pin = st_reg.lock_flag;
        else if (st_reg.lock_mode[LK_SHARE_BIT - LK_SKEW_BIT])
            lock_or_serial_out_pin = st_reg.reading ? serial_data_out : st_reg.lock_flag;
        else
            lock_or_serial_out_pin = serial_data_out;
    end

    // loop control codes
    always_comb
    begin
        loop_ctrl.pump_rise_gain    = st_reg.gain_codes[4:0];
        loop_ctrl.pump_fall_gain    = st_reg.gain_codes[GAIN_FALL_LSB +: 5];
        loop_ctrl.pump_rise_fine    = st_reg.trim_codes[2:0];
        loop_ctrl.pump_fall_fine    = st_reg.trim_codes[TRIM_FALL_LSB +: 3];
        loop_ctrl.pump_rise_leak    = st_reg.trim_codes[LEAK_RISE_LSB +: 4];
        loop_ctrl.pump_fall_leak    = st_reg.trim_codes[LEAK_FALL_LSB +: 4];
        loop_ctrl.detector_gain_max = st_reg.guard_on;
        loop_ctrl.modulator_run     = st_reg.enable[EN_DSM_BIT] && !st_reg.dsm_int;
        loop_ctrl.divide_value      = nudged;
    end

    // lock needs enable and a preceding run of hits
    a_lock_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_reg.enable[EN_LOCK_BIT] |=> !lock_flag) else $error("lock flag set while disabled");
    a_miss_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        miss |=> !lock_flag && st_reg.hit_count == 10'h000) else $error("miss did not clear lock");
    a_floor_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.guard_on && !arrival.vco_lead |-> loop_ctrl.divide_value >= MIN_DIVIDE)
        else $error("divide below floor");
    a_force_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.lock_mode[LK_FORCE_BIT - LK_SKEW_BIT] |-> lock_or_serial_out_pin == lock_flag)
        else $error("pin not forced");
    a_guard_en: assert property (@(posedge aclk) disable iff (!aresetn)
        loop_ctrl.detector_gain_max |-> $past(st_reg.enable[EN_SLIP_BIT])) else $error("guard without enable");
    a_int_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.dsm_int |-> !loop_ctrl.modulator_run) else $error("modulator runs in integer mode");
    a_lock_rise: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(lock_flag) |-> $past(hit) && $past(st_reg.hit_count) + 10'h001 >= $past(st_reg.win_target))
        else $error("lock rose without target");
    a_share_read: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_reg.lock_mode[LK_FORCE_BIT - LK_SKEW_BIT] && st_reg.lock_mode[LK_SHARE_BIT - LK_SKEW_BIT]
        && st_reg.reading |-> lock_or_serial_out_pin == serial_data_out)
        else $error("share pin not serial during read");
endmodule : pld_core
`default_nettype wire

//--- testbench/pld_front_model.sv
/*
 * phase detector front end model: arrival pulses and serial read data.
 * assumes the bench calls arrive() from its main thread, one at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module pld_front_model
(
    input  wire logic             aclk,
    output pld_pkg::pld_arrival_t arrival,
    output logic                  serial_data_out
);
    import pld_pkg::*;
    initial arrival = '0;
    initial serial_data_out = 1'b0;
    // read data flips every cycle so a stale copy never matches
    always @(posedge aclk)
        serial_data_out <= ~serial_data_out;
    // one arrival pulse; window bits and levels stay after it
    task automatic arrive(input logic [2:0] win, input logic fn, input logic ld);
        @(posedge aclk);
        arrival <= {1'b1, win, fn, ld};
        @(posedge aclk);
        arrival.valid <= 1'b0;
    endtask : arrive
endmodule : pld_front_model
`default_nettype wire

//--- testbench/testbench.sv
/*
 * bench for pld_core: register tests over AXI4-Lite, lock, pin, pump,
 * mode and slip checks. assumes pld_front_model stands at the detector side.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench;
    import pld_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, pin, flag, sdo;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    pld_arrival_t arrival;
    pld_loop_t    lc;
    int          err_count = 0, num_checks = 0, cyc = 0;
    // 10 MHz clock
    always #50 aclk = ~aclk;
    pld_front_model fm (.aclk(aclk), .arrival(arrival), .serial_data_out(sdo));
    pld_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .arrival(arrival),
        .serial_data_out(sdo), .lock_or_serial_out_pin(pin), .lock_flag(flag), .loop_ctrl(lc));
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // hang guard
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    // one write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ap, wp;
        ap = 1;
        wp = 1;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (ap || wp)
        begin
            @(posedge aclk);
            if (ap && awready) begin ap = 0; awvalid <= 0; end
            if (wp && wready) begin wp = 0; wvalid <= 0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
        `CHK("bresp", er, bresp)
        #1;
    endtask : wr
    // one read; data compared only when an okay answer is expected
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
        `CHK("rresp", er, rresp)
        if (er == RESP_OKAY) `CHK("rdata", e, rdata)
        #1;
    endtask : rd
    // n arrivals with the given window bits, then the flag is compared
    task automatic hits(input int n, input logic [2:0] w, input logic e);
        repeat (n) fm.arrive(w, 1'b1, 1'b0);
        #1;
        `CHK("lock_flag", e, flag)
    endtask : hits
    // slip guard arrival, then gain and divide compared
    task automatic slip(input logic fn, input logic ld, input logic g, input logic [15:0] dv);
        fm.arrive(3'b000, fn, ld);
        #1;
        `CHK("gain_max", g, lc.detector_gain_max)
        `CHK("divide", dv, lc.divide_value)
    endtask : slip
    // main sequence
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rd(ADDR_ENABLE, 32'h0000_2000, RESP_OKAY);
        rd(ADDR_INTG, 32'h0000_0024, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
        rd(8'h08, 32'h0, RESP_SLVERR);
        wr(8'h08, 32'h1, RESP_SLVERR);
        `CHK("modulator_run", 1'b1, lc.modulator_run)
        $display("test reset done");
        wr(ADDR_LOCK_CFG, 32'h0000_1003, RESP_OKAY);
        wr(ADDR_ENABLE, 32'h0000_2800, RESP_OKAY);
        hits(2, 3'b010, 1'b0);
        hits(1, 3'b010, 1'b1);
        rd(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
        `CHK("pin", 1'b1, pin)
        hits(2, 3'b010, 1'b1);
        hits(1, 3'b000, 1'b0);
        hits(2, 3'b010, 1'b0);
        hits(1, 3'b010, 1'b1);
        `CHK("pin", 1'b1, pin)
        wr(ADDR_ENABLE, 32'h0000_2000, RESP_OKAY);
        `CHK("lock_flag", 1'b0, flag)
        hits(3, 3'b010, 1'b0);
        $display("test lock done");
        wr(ADDR_ENABLE, 32'h0000_2800, RESP_OKAY);
        wr(ADDR_LOCK_CFG, 32'h0000_2C01, RESP_OKAY);
        hits(1, 3'b010, 1'b0);
        `CHK("pin", 1'b0, pin)
        hits(1, 3'b001, 1'b1);
        `CHK("pin", 1'b1, pin)
        wr(ADDR_LOCK_CFG, 32'h0000_0401, RESP_OKAY);
        hits(1, 3'b001, 1'b0);
        hits(1, 3'b100, 1'b1);
        `CHK("pin", sdo, pin)
        // serial data flips each cycle, the flag does not: look twice
        @(posedge aclk);
        #1;
        `CHK("pin", sdo, pin)
        // mid-run reset with the flag set
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        `CHK("lock_flag", 1'b0, flag)
        rd(ADDR_LOCK_CFG, 32'h0000_0000, RESP_OKAY);
        rd(ADDR_ENABLE, 32'h0000_2000, RESP_OKAY);
        $display("test window done");
        wr(ADDR_PUMP_GAIN, 32'h0000_0155, RESP_OKAY);
        `CHK("rise_gain", 5'h15, lc.pump_rise_gain)
        `CHK("fall_gain", 5'h0A, lc.pump_fall_gain)
        wr(ADDR_PUMP_TRIM, 32'h0000_24D5, RESP_OKAY);
        `CHK("rise_fine", 3'h5, lc.pump_rise_fine)
        `CHK("fall_fine", 3'h2, lc.pump_fall_fine)
        `CHK("rise_leak", 4'h3, lc.pump_rise_leak)
        `CHK("fall_leak", 4'h9, lc.pump_fall_leak)
        wr(ADDR_DSM_CFG, 32'h0000_0008, RESP_OKAY);
        `CHK("modulator_run", 1'b0, lc.modulator_run)
        `CHK("divide", 16'h0024, lc.divide_value)
        wr(ADDR_DSM_CFG, 32'h0000_0000, RESP_OKAY);
        `CHK("modulator_run", 1'b1, lc.modulator_run)
        $display("test pump and mode done");
        wr(ADDR_INTG, 32'h0000_0064, RESP_OKAY);
        wr(ADDR_SLIP_CFG, 32'h0000_0004, RESP_OKAY);
        wr(ADDR_ENABLE, 32'h0000_A000, RESP_OKAY);
        slip(1'b0, 1'b1, 1'b1, 16'h0068);
        slip(1'b0, 1'b0, 1'b1, 16'h0060);
        slip(1'b1, 1'b0, 1'b0, 16'h0064);
        wr(ADDR_INTG, 32'h0000_0024, RESP_OKAY);
        wr(ADDR_SLIP_CFG, 32'h0000_0007, RESP_OKAY);
        slip(1'b0, 1'b0, 1'b1, 16'h0020);
        wr(ADDR_ENABLE, 32'h0000_2000, RESP_OKAY);
        slip(1'b0, 1'b1, 1'b0, 16'h0024);
        $display("test slip done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
